// [rtl/rtcpc_top.sv]
/*
 RTC pin control: clock-out gating, wake pin direction and open-drain alarm
 signalling, and blocking of the RTC register window while the oscillator
 is off.
 Assumes all inputs synchronous to clk; the pad ring resolves the wake wire
 from wake_pin_oe with an external pull-up.
*/
// Summary of operation
// RULE1: The clock output pin is driven only while the clock-out enable bit is set, else it floats.
// RULE2: After reset the clock output pin is disabled and floating until software enables it.
// RULE3: With the wake pin as input, a low from outside brings the core out of idle.
// RULE4: The wake pin becomes an input whenever the RTC core supply powers up.
// RULE5: As an output the wake pin is active-low open drain, pulled low on an RTC alarm.
// RULE6: While the RTC oscillator is off, accesses to 1900h through 197Fh are refused.
// RULE7: In open-drain mode the wake pin is released whenever no alarm is being signalled.
`timescale 1ns/1ns
`default_nettype none

module rtcpc_top
(
    input  wire logic       clk,               // 20 MHz clock
    input  wire logic       reset,             // Synchronous reset, active high
    input  wire logic       rtc_clk_src,       // RTC clock level to present on the pin
    input  wire logic       rtc_clock_out_enable, // Enable bit of the power management register
    input  wire logic       wake_out_mode,     // Wake pin configured as output
    input  wire logic       rtc_supply_up,     // RTC core supply good level
    input  wire logic       rtc_osc_on,        // RTC oscillator running
    input  wire logic       rtc_alarm,         // RTC alarm level
    input  wire logic       core_idle,         // Core currently idle
    input  wire logic       wake_pin_i,        // Wake pin level seen at the pad
    input  wire rtcpc_pkg::rtcpc_req_t req,    // Register window request
    output var  rtcpc_pkg::rtcpc_rsp_t rsp,    // Register window response
    output logic            rtc_clock_out_pin_o,  // Clock pin output value
    output logic            rtc_clock_out_pin_oe, // Clock pin drive enable
    output logic            wake_pin_o,        // Wake pin output value, always low
    output logic            wake_pin_oe,       // Wake pin pull-down enable
    output logic            core_wake,         // One-cycle resume pulse to the core
    output logic            wake_is_output     // Wake pin direction, from register
);
    import rtcpc_pkg::*;

    typedef struct packed {
        rtcpc_state_t st;
        logic         clk_oe;
        logic         clk_o;
        logic         wake_oe;
        logic         wake_pulse;
        logic         supply_q;
        logic         wake_in_q;
        logic         ack;
        logic         err;
        logic         rd_pend;
        logic [15:0]  rdata;
    } rtcpc_regs_t;

    rtcpc_regs_t r_reg;
    rtcpc_regs_t r_next;
    logic [15:0] mem_rdata;
    logic        in_win;
    logic        mem_we;

    function automatic logic win_hit(input logic [15:0] a);
        win_hit = (a >= RTC_WIN_LO) && (a <= RTC_WIN_HI);
    endfunction

    always_comb
    begin
        in_win = req.valid && win_hit(req.addr);
        mem_we = in_win && req.write && rtc_osc_on;                 // [RULE6]
    end

    always_comb
    begin
        r_next            = r_reg;
        r_next.wake_pulse = 1'b0;
        r_next.ack        = 1'b0;
        r_next.err        = 1'b0;
        r_next.rd_pend    = 1'b0;
        r_next.rdata      = 16'h0000;
        r_next.supply_q   = rtc_supply_up;
        r_next.wake_in_q  = wake_pin_i;
        // Clock pin follows the enable bit; data registered to avoid glitches
        r_next.clk_oe     = rtc_clock_out_enable;                   // [RULE1]
        r_next.clk_o      = rtc_clock_out_enable & rtc_clk_src;     // [RULE1]
        case (r_reg.st)
            RTCPC_ST_INPUT:
            begin
                r_next.wake_oe = 1'b0;
                // Falling edge while idle resumes the core
                if (r_reg.wake_in_q && !wake_pin_i && core_idle)
                begin
                    r_next.wake_pulse = 1'b1;                       // [RULE3]
                    r_next.st         = RTCPC_ST_WAKE;
                end
                else if (wake_out_mode)
                begin
                    r_next.st = RTCPC_ST_DRIVE;
                end
            end
            RTCPC_ST_WAKE:
            begin
                // One pulse per low period; wait for release
                if (wake_pin_i)
                begin
                    r_next.st = RTCPC_ST_INPUT;
                end
            end
            RTCPC_ST_DRIVE:
            begin
                r_next.wake_oe = rtc_alarm;                         // [RULE5] [RULE7]
                if (!wake_out_mode)
                begin
                    r_next.st      = RTCPC_ST_INPUT;
                    r_next.wake_oe = 1'b0;
                end
            end
            default:
            begin
                r_next.st      = RTCPC_ST_INPUT;
                r_next.wake_oe = 1'b0;
            end
        endcase
        // Supply coming up overrides any software direction
        if (rtc_supply_up && !r_reg.supply_q)
        begin
            r_next.st      = RTCPC_ST_INPUT;                        // [RULE4]
            r_next.wake_oe = 1'b0;                                  // [RULE4]
        end
        if (in_win)
        begin
            if (!rtc_osc_on)
            begin
                r_next.err = 1'b1;                                  // [RULE6]
                r_next.ack = 1'b1;
            end
            else if (req.write)
            begin
                r_next.ack = 1'b1;
            end
            else
            begin
                r_next.rd_pend = 1'b1;
            end
        end
        // Capture read word now; the address need not stand past the request
        if (r_reg.rd_pend)
        begin
            r_next.ack   = 1'b1;
            r_next.rdata = mem_rdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            r_reg.st         <= RTCPC_ST_INPUT;
            r_reg.clk_oe     <= CLKOUT_EN_RST;                      // [RULE2]
            r_reg.clk_o      <= 1'b0;
            r_reg.wake_oe    <= WAKE_OUT_RST;
            r_reg.wake_pulse <= 1'b0;
            r_reg.supply_q   <= 1'b0;
            r_reg.wake_in_q  <= 1'b1;
            r_reg.ack        <= 1'b0;
            r_reg.err        <= 1'b0;
            r_reg.rd_pend    <= 1'b0;
            r_reg.rdata      <= 16'h0000;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    rtcpc_win_mem u_mem (
        .clk   (clk),
        .we    (mem_we),
        .addr  (req.addr[WIN_AW-1:0]),
        .wdata (req.wdata),
        .rdata (mem_rdata)
    );

    assign rtc_clock_out_pin_oe = r_reg.clk_oe;
    assign rtc_clock_out_pin_o  = r_reg.clk_o;
    assign wake_pin_o           = 1'b0;
    assign wake_pin_oe          = r_reg.wake_oe;
    assign core_wake            = r_reg.wake_pulse;
    assign wake_is_output       = (r_reg.st == RTCPC_ST_DRIVE);
    assign rsp                  = '{ack: r_reg.ack, err: r_reg.err, rdata: r_reg.rdata};

    property p_clk_gate;
        @(posedge clk) disable iff (reset)
        !rtc_clock_out_enable |=> !rtc_clock_out_pin_oe;
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("clock pin driven while disabled"); // [RULE1]

    property p_clk_on;
        @(posedge clk) disable iff (reset)
        rtc_clock_out_enable |=> rtc_clock_out_pin_oe && (rtc_clock_out_pin_o == $past(rtc_clk_src));
    endproperty
    a_clk_on: assert property (p_clk_on) else $error("clock pin not following source"); // [RULE1]

    property p_clk_reset;
        @(posedge clk)
        $fell(reset) |-> !rtc_clock_out_pin_oe;
    endproperty
    a_clk_reset: assert property (p_clk_reset) else $error("clock pin enabled after reset"); // [RULE2]

    property p_wake_resume;
        @(posedge clk) disable iff (reset)
        (r_reg.st == RTCPC_ST_INPUT) && r_reg.wake_in_q && !wake_pin_i && core_idle
            |=> core_wake ##1 !core_wake;
    endproperty
    a_wake_resume: assert property (p_wake_resume) else $error("no resume on wake pin"); // [RULE3]

    property p_supply_input;
        @(posedge clk) disable iff (reset)
        $rose(rtc_supply_up) |=> !wake_is_output && !wake_pin_oe;
    endproperty
    a_supply_input: assert property (p_supply_input) else $error("wake pin not input on powerup"); // [RULE4]

    property p_alarm_pull;
        @(posedge clk) disable iff (reset)
        wake_is_output && wake_out_mode && rtc_alarm && !(rtc_supply_up && !r_reg.supply_q)
            |=> wake_pin_oe && !wake_pin_o;
    endproperty
    a_alarm_pull: assert property (p_alarm_pull) else $error("alarm not signalled low"); // [RULE5]

    property p_win_block;
        @(posedge clk) disable iff (reset)
        req.valid && win_hit(req.addr) && !rtc_osc_on |-> !mem_we ##1 (rsp.ack && rsp.err);
    endproperty
    a_win_block: assert property (p_win_block) else $error("window access while osc off"); // [RULE6]

    property p_release;
        @(posedge clk) disable iff (reset)
        !rtc_alarm |=> !wake_pin_oe;
    endproperty
    a_release: assert property (p_release) else $error("wake pin held without alarm"); // [RULE7]

    c_clk_on: cover property (@(posedge clk) disable iff (reset) rtc_clock_out_pin_oe);
    c_wake: cover property (@(posedge clk) disable iff (reset) core_wake);
    c_alarm: cover property (@(posedge clk) disable iff (reset) wake_pin_oe);
    c_block: cover property (@(posedge clk) disable iff (reset) rsp.err);

endmodule

`default_nettype wire

// [rtl/rtcpc_pkg.sv]
/*
 Package for the RTC pin control block: shared constants, state codes and
 the packed structs that carry pin groups and access requests.
 Assumes a single 20 MHz clock domain and a synchronous active-high reset.
*/
package rtcpc_pkg;

    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned ADDR_W        = 16;
    localparam int unsigned DATA_W        = 16;

    // RTC register window in I/O space
    localparam logic [15:0] RTC_WIN_LO = 16'h1900;
    localparam logic [15:0] RTC_WIN_HI = 16'h197F;

    // Reset values of the control bits
    localparam logic CLKOUT_EN_RST = 1'b0;
    localparam logic WAKE_OUT_RST  = 1'b0;

    // Slot count of the window shadow memory
    localparam int unsigned WIN_WORDS  = 128;
    localparam int unsigned WIN_AW     = 7;

    typedef enum logic [2:0] {
        RTCPC_ST_INPUT = 3'b001,
        RTCPC_ST_WAKE  = 3'b010,
        RTCPC_ST_DRIVE = 3'b100
    } rtcpc_state_t;

    // Open-drain or three-state pin, two signals at the port
    typedef struct packed {
        logic o;
        logic oe;
    } rtcpc_pin_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [15:0]       addr;
        logic [15:0]       wdata;
    } rtcpc_req_t;

    typedef struct packed {
        logic              ack;
        logic              err;
        logic [15:0]       rdata;
    } rtcpc_rsp_t;

endpackage

// [rtl/rtcpc_win_mem.sv]
/*
 Small synchronous memory standing for the RTC register window contents.
 Read data come out of a register one cycle after the address.
 Assumes the caller gates writes; no reset of the array contents.
*/
`timescale 1ns/1ns
`default_nettype none

module rtcpc_win_mem
    import rtcpc_pkg::*;
(
    input  wire logic              clk,    // System clock
    input  wire logic              we,     // Write strobe
    input  wire logic [WIN_AW-1:0] addr,   // Word index
    input  wire logic [15:0]       wdata,  // Write data
    output logic      [15:0]       rdata   // Registered read data
);

    logic [15:0] mem [WIN_WORDS];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule

`default_nettype wire

// [tb/rtcpc_wake_partner.sv]
/*
 External party on the wake wire: pull-up plus a pull-low driver that the
 bench commands.
 Assumes the wire is resolved from every open-drain enable.
*/
`timescale 1ns/1ns
`default_nettype none

module rtcpc_wake_partner
(
    input  wire logic clk,         // System clock
    input  wire logic dev_pull_oe, // Device pull-low enable
    input  wire logic dev_pull_o,  // Device drive value
    input  wire logic pull_low,    // Bench command to assert wake
    output logic      wake_wire,   // Resolved wire level
    output logic      woken        // Low seen on the wire last edge
);
    // Nobody drives high; a released wire sits at the pull-up
    assign wake_wire = !((dev_pull_oe && !dev_pull_o) || pull_low);

    always_ff @(posedge clk)
    begin
        woken <= !wake_wire;
    end
endmodule

`default_nettype wire

// [tb/test_rtc_pin_control.sv]
/*
 Self-checking bench for the RTC pin control block with a model of the
 window memory.
 Assumes the wake partner model resolves the wake wire.
*/
`timescale 1ns/1ns
`default_nettype none

module test_rtc_pin_control;
    import rtcpc_pkg::*;

    logic        clk      = 1'b0;
    logic        reset    = 1'b1;
    logic        src      = 1'b0;
    logic        clk_en   = 1'b0;
    logic        out_mode = 1'b0;
    logic        supply   = 1'b1;
    logic        osc      = 1'b1;
    logic        alarm    = 1'b0;
    logic        idle     = 1'b0;
    logic        pull_low = 1'b0;
    rtcpc_req_t  req      = '0;
    rtcpc_rsp_t  rsp;
    logic        wake_wire, woken, ck_o, ck_oe, wk_o, wk_oe, core_wake, wake_is_out;
    logic        seen_ack, seen_err, hit, prev_en, prev_src;
    logic [15:0] seen_data, a_tmp;
    logic [15:0] addr_q [$];
    int          mdl [int];
    int          num_errors = 0;
    int          num_checks = 0;
    int          seed       = 81;
    int          cycles     = 0;
    int          n;

    rtcpc_top dut_u (
        .clk(clk), .reset(reset), .rtc_clk_src(src), .rtc_clock_out_enable(clk_en),
        .wake_out_mode(out_mode), .rtc_supply_up(supply), .rtc_osc_on(osc), .rtc_alarm(alarm),
        .core_idle(idle), .wake_pin_i(wake_wire), .req(req), .rsp(rsp), .rtc_clock_out_pin_o(ck_o),
        .rtc_clock_out_pin_oe(ck_oe), .wake_pin_o(wk_o), .wake_pin_oe(wk_oe), .core_wake(core_wake),
        .wake_is_output(wake_is_out)
    );

    rtcpc_wake_partner partner_u (
        .clk(clk), .dev_pull_oe(wk_oe), .dev_pull_o(wk_o), .pull_low(pull_low),
        .wake_wire(wake_wire), .woken(woken)
    );

    always #25 clk = ~clk;

    // Whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            num_errors++;
            results();
        end
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Valid for one cycle, then first ack within four cycles is taken
    task access(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{1'b1, wr, a, d};
        @(posedge clk);
        req.valid <= 1'b0;
        seen_ack = 1'b0;
        repeat (4)
        begin
            @(negedge clk);
            if (rsp.ack === 1'b1 && !seen_ack)
            begin
                seen_ack  = 1'b1;
                seen_err  = rsp.err;
                seen_data = rsp.rdata;
            end
        end
    endtask

    task win(input logic wr, input logic [15:0] a, input logic [15:0] d);
        access(wr, a, d);
        if (a < RTC_WIN_LO || a > RTC_WIN_HI)
            check(16'(seen_ack), 16'h0000);
        else
        begin
            check(16'(seen_ack), 16'h0001);
            check(16'(seen_err), 16'(!osc));
            if (!wr)
                check(seen_data, osc ? 16'(mdl[int'(a[6:0])]) : 16'h0000);
            if (wr && osc)
                mdl[int'(a[6:0])] = int'(d);
        end
    endtask

    task wake_try(output int cnt);
        @(posedge clk);
        pull_low <= 1'b1;
        cnt = 0;
        repeat (4)
        begin
            @(negedge clk);
            if (core_wake === 1'b1)
                cnt++;
        end
        @(posedge clk);
        pull_low <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check(16'(ck_oe), 16'h0000);
        check(16'(wk_oe), 16'h0000);
        check(16'(wake_is_out), 16'h0000);
        prev_en  = 1'b0;
        prev_src = 1'b0;
        repeat (40)
        begin
            @(posedge clk);
            clk_en <= 1'($random(seed));
            src    <= 1'($random(seed));
            @(negedge clk);
            check(16'(ck_oe), 16'(prev_en));
            if (prev_en)
                check(16'(ck_o), 16'(prev_src));
            prev_en  = clk_en;
            prev_src = src;
        end
        addr_q = {RTC_WIN_LO, RTC_WIN_HI};
        repeat (6)
        begin
            a_tmp = RTC_WIN_LO + 16'(7'($random(seed)));
            addr_q.push_back(a_tmp);
        end
        foreach (addr_q[i])
            win(1'b1, addr_q[i], 16'($random(seed)));
        foreach (addr_q[i])
            win(1'b0, addr_q[i], 16'h0000);
        @(posedge clk);
        osc <= 1'b0;
        win(1'b1, RTC_WIN_LO, 16'hFFFF);
        win(1'b0, RTC_WIN_LO, 16'h0000);
        @(posedge clk);
        osc <= 1'b1;
        win(1'b0, RTC_WIN_LO, 16'h0000);
        win(1'b1, 16'h18FF, 16'h1234);
        win(1'b0, 16'h1980, 16'h0000);
        @(posedge clk);
        idle <= 1'b1;
        wake_try(n);
        check(16'(n), 16'h0001);
        idle <= 1'b0;
        wake_try(n);
        check(16'(n), 16'h0000);
        @(posedge clk);
        out_mode <= 1'b1;
        alarm    <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(16'(wake_is_out), 16'h0001);
        check(16'(wk_oe), 16'h0001);
        check(16'(wk_o), 16'h0000);
        check(16'(woken), 16'h0001);
        @(posedge clk);
        alarm <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(16'(wk_oe), 16'h0000);
        check(16'(wake_wire), 16'h0001);
        @(posedge clk);
        supply <= 1'b0;
        @(posedge clk);
        supply <= 1'b1;
        hit = 1'b0;
        repeat (3)
        begin
            @(negedge clk);
            if (wake_is_out === 1'b0)
                hit = 1'b1;
        end
        check(16'(hit), 16'h0001);
        results();
    end
endmodule

`default_nettype wire
